/* inc/pam_pkg.sv */
/*
 * Constants of the phase and AM settings block: register offsets,
 * field positions, limits and reset values.
 * Assumes a 32-bit APB master and byte addresses.
 */
package pam_pkg;
    // ************************************
    // Register offsets
    // ************************************
    localparam logic [7:0] OFF_PHASE   = 8'h00;
    localparam logic [7:0] OFF_CTRL    = 8'h04;
    localparam logic [7:0] OFF_LOCKEN  = 8'h08;
    localparam logic [7:0] OFF_ERR     = 8'h0C;
    localparam logic [7:0] OFF_DEPTH   = 8'h10;
    localparam logic [7:0] OFF_SHAPE   = 8'h14;
    localparam logic [7:0] OFF_RATE    = 8'h18;
    localparam logic [7:0] OFF_SOURCE  = 8'h1C;
    localparam logic [7:0] OFF_AMSTATE = 8'h20;
    localparam logic [7:0] OFF_MODE    = 8'h24;
    localparam logic [7:0] OFF_CARSHP  = 8'h28;
    localparam logic [7:0] OFF_CARF_LO = 8'h2C;
    localparam logic [7:0] OFF_CARF_HI = 8'h30;
    localparam logic [7:0] OFF_BURSTPH = 8'h34;
    localparam logic [7:0] OFF_STATUS  = 8'h38;
    // ************************************
    // Field positions
    // ************************************
    localparam int PH_DEG_BIT  = 16;
    localparam int SEL_LSB_PH  = 17;
    localparam int SEL_LSB_DEP = 8;
    localparam int SEL_LSB_RT  = 25;
    localparam int ERR_FLAG    = 16;
    localparam logic [1:0] SEL_VAL = 2'h0;
    localparam logic [1:0] SEL_MIN = 2'h1;
    localparam logic [1:0] SEL_MAX = 2'h2;
    // ************************************
    // Limits and reset values
    // ************************************
    localparam logic signed [15:0] PH_MAX_Q12 = 16'sh6488;
    localparam logic signed [15:0] DEG_MAX    = 16'sh0168;
    localparam logic signed [9:0]  DEG_Q12_X2 = 10'sh08F;
    localparam logic [39:0] DEP_MAX    = 40'h78;
    localparam logic [39:0] DEP_RST    = 40'h64;
    localparam logic [39:0] RATE_MIN   = 40'hA;
    localparam logic [39:0] RATE_MAX   = 40'h1312D00;
    localparam logic [39:0] RATE_RST   = 40'h186A0;
    localparam logic [39:0] CARF_MIN   = 40'h1;
    localparam logic [39:0] CARF_MAX   = 40'h22ECB25C00;
    localparam logic [39:0] CARF_TRMAX = 40'h3B9ACA00;
    localparam logic [39:0] CARF_RST   = 40'h989680;
    localparam logic [9:0]  ERR_UNLOCK = 10'h244;
    // ************************************
    // Encodings
    // ************************************
    typedef enum logic [2:0] {
        SH_SIN = 3'h0, SH_SQU = 3'h1, SH_TRI = 3'h2, SH_RAMP = 3'h3,
        SH_NOISE = 3'h4, SH_USER = 3'h5, SH_DC = 3'h6
    } pam_shape_t;
    typedef enum logic [5:0] {
        MD_NONE = 6'h01, MD_AM = 6'h02, MD_FM = 6'h04,
        MD_BURST = 6'h08, MD_FSK = 6'h10, MD_SWEEP = 6'h20
    } pam_mode_t;
endpackage

/* src/pam_ctrl.sv */
/*
 * Phase offset, lock-loss error and AM settings behind an APB slave.
 * Assumes one clock, a lock level arriving from a pin and an APB
 * master that keeps each request until PREADY.
 */
// Local design decisions: the APB interface to the registers and the register offsets.
module pam_ctrl
    import pam_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        CE_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        LOCK_I,
    output logic      [15:0] PHASE_OFFSET_O,
    output logic             PHASE_REBASE_O,
    output logic      [15:0] BURST_PHASE_O,
    output logic             ZERO_FIRST_SAMPLE_O,
    output logic             LOCK_ERR_O,
    output logic      [7:0]  AM_DEPTH_O,
    output logic      [2:0]  AM_SHAPE_O,
    output logic      [24:0] AM_RATE_O,
    output logic             INT_MOD_EN_O,
    output logic             EXT_MOD_EN_O,
    output logic             DEPTH_FROM_EXT_O,
    output logic      [5:0]  MOD_MODE_O,
    output logic      [39:0] CARRIER_FREQ_O
);
    // ************************************
    // Helpers
    // ************************************
    function automatic logic hit(input logic [7:0] a);
        case (a)
            OFF_PHASE, OFF_CTRL, OFF_LOCKEN, OFF_ERR, OFF_DEPTH,
            OFF_SHAPE, OFF_RATE, OFF_SOURCE, OFF_AMSTATE, OFF_MODE,
            OFF_CARSHP, OFF_CARF_LO, OFF_CARF_HI, OFF_BURSTPH,
            OFF_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    endfunction

    function automatic logic [39:0] pick(input logic [1:0] s,
        input logic [39:0] v, input logic [39:0] mn,
        input logic [39:0] mx);
        if (s == SEL_MIN) pick = mn;
        else if (s == SEL_MAX) pick = mx;
        else if (v < mn) pick = mn;
        else if (v > mx) pick = mx;
        else pick = v;
    endfunction

    function automatic logic signed [15:0] to_rad(input logic [18:0] w);
        logic signed [15:0] v;
        logic signed [25:0] p;
        v = w[15:0];
        p = 26'sh0;
        // Degrees rescaled first; 360 deg lands just past two pi
        if (w[PH_DEG_BIT]) begin
            if (v > DEG_MAX) v = DEG_MAX;
            if (v < -DEG_MAX) v = -DEG_MAX;
            p = v * DEG_Q12_X2;
            v = p[16:1];
        end
        if (w[SEL_LSB_PH+:2] == SEL_MIN) to_rad = -PH_MAX_Q12;
        else if (w[SEL_LSB_PH+:2] == SEL_MAX) to_rad = PH_MAX_Q12;
        else if (v > PH_MAX_Q12) to_rad = PH_MAX_Q12;
        else if (v < -PH_MAX_Q12) to_rad = -PH_MAX_Q12;
        else to_rad = v;
    endfunction

    // ************************************
    // APB slave
    // ************************************
    logic       setup;
    logic       wr;
    logic [31:0] nxt_rd;
    logic [15:0] phase_ff;
    logic        lock_en_ff;
    logic        err_ff;
    logic        conflict_ff;
    logic [7:0]  depth_ff;
    logic [2:0]  shape_ff;
    logic [24:0] rate_ff;
    logic        ext_only_ff;
    pam_mode_t   mode_ff;
    logic [2:0]  car_ff;
    logic [39:0] carf_ff;
    logic [15:0] burst_ff;
    logic [2:0]  lk_ff;
    logic        lock_ff;
    logic        car_bad;

    assign setup = PSEL_I & ~PENABLE_I & CE_I;
    assign wr = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O & CE_I
                & hit(PADDR_I);
    assign car_bad = (car_ff == SH_NOISE) | (car_ff == SH_DC);

    always_comb begin
        nxt_rd = 32'h0;
        case (PADDR_I)
            OFF_PHASE:   nxt_rd = {{16{phase_ff[15]}}, phase_ff};
            OFF_LOCKEN:  nxt_rd = {31'h0, lock_en_ff};
            OFF_ERR:     nxt_rd = {15'h0, err_ff, 6'h0,
                                   err_ff ? ERR_UNLOCK : 10'h0};
            OFF_DEPTH:   nxt_rd = {24'h0, depth_ff};
            OFF_SHAPE:   nxt_rd = {29'h0, shape_ff};
            OFF_RATE:    nxt_rd = {7'h0, rate_ff};
            OFF_SOURCE:  nxt_rd = {31'h0, ext_only_ff};
            OFF_AMSTATE: nxt_rd = {31'h0, mode_ff == MD_AM};
            OFF_MODE:    nxt_rd = {26'h0, mode_ff};
            OFF_CARSHP:  nxt_rd = {29'h0, car_ff};
            OFF_CARF_LO: nxt_rd = carf_ff[31:0];
            OFF_CARF_HI: nxt_rd = {24'h0, carf_ff[39:32]};
            OFF_BURSTPH: nxt_rd = {16'h0, burst_ff};
            OFF_STATUS:  nxt_rd = {30'h0, conflict_ff, lock_ff};
            default:     nxt_rd = 32'h0;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0;
            PSLVERR_O <= 1'b0;
        end else if (CE_I) begin
            PREADY_O <= PSEL_I & ~PENABLE_I;
            if (setup) begin
                PRDATA_O  <= PWRITE_I ? 32'h0 : nxt_rd;
                PSLVERR_O <= ~hit(PADDR_I);
            end
        end
    end

    // ************************************
    // Phase settings
    // ************************************
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            phase_ff   <= 16'h0;
            burst_ff   <= 16'h0;
            lock_en_ff <= 1'b0;
            PHASE_REBASE_O <= 1'b0;
        end else if (CE_I) begin
            PHASE_REBASE_O <= wr & (PADDR_I == OFF_CTRL) & PWDATA_I[0];
            if (wr && PADDR_I == OFF_PHASE)
                phase_ff <= to_rad(PWDATA_I[18:0]);
            if (wr && PADDR_I == OFF_BURSTPH)
                burst_ff <= PWDATA_I[15:0];
            if (wr && PADDR_I == OFF_LOCKEN)
                lock_en_ff <= PWDATA_I[0];
        end
    end

    // ************************************
    // Lock input and error latch
    // ************************************
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            lk_ff   <= 3'h0;
            lock_ff <= 1'b0;
        end else if (CE_I) begin
            lk_ff <= {lk_ff[1:0], LOCK_I};
            if (lk_ff[1] == lk_ff[2])
                lock_ff <= lk_ff[2];
        end
    end

    logic loss;
    assign loss = lock_ff & (lk_ff[1] == lk_ff[2]) & ~lk_ff[2];

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) err_ff <= 1'b0;
        else if (CE_I) begin
            if (loss && lock_en_ff) err_ff <= 1'b1;
            else if (wr && PADDR_I == OFF_ERR && PWDATA_I[ERR_FLAG])
                err_ff <= 1'b0;
        end
    end

    // ************************************
    // AM settings
    // ************************************
    logic [39:0] nxt_dep;
    logic [39:0] nxt_rate;
    assign nxt_dep = pick(PWDATA_I[SEL_LSB_DEP+:2],
                          {32'h0, PWDATA_I[7:0]}, 40'h0, DEP_MAX);
    assign nxt_rate = pick(PWDATA_I[SEL_LSB_RT+:2],
                           {15'h0, PWDATA_I[24:0]}, RATE_MIN, RATE_MAX);

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            depth_ff    <= DEP_RST[7:0];
            shape_ff    <= SH_SIN;
            rate_ff     <= RATE_RST[24:0];
            ext_only_ff <= 1'b0;
        end else if (CE_I) begin
            if (wr && PADDR_I == OFF_DEPTH)
                depth_ff <= nxt_dep[7:0];
            if (wr && PADDR_I == OFF_SHAPE && PWDATA_I[2:0] <= SH_USER)
                shape_ff <= PWDATA_I[2:0];
            if (wr && PADDR_I == OFF_RATE)
                rate_ff <= nxt_rate[24:0];
            if (wr && PADDR_I == OFF_SOURCE)
                ext_only_ff <= PWDATA_I[0];
        end
    end

    // ************************************
    // Carrier and modulation mode
    // ************************************
    logic am_req;
    assign am_req = wr & (PADDR_I == OFF_AMSTATE) & PWDATA_I[0];

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            car_ff  <= SH_SIN;
            carf_ff <= CARF_RST;
        end else if (CE_I) begin
            if (wr && PADDR_I == OFF_CARSHP && PWDATA_I[2:0] <= SH_DC)
                car_ff <= PWDATA_I[2:0];
            if (wr && PADDR_I == OFF_CARF_LO)
                carf_ff[31:0] <= PWDATA_I;
            if (wr && PADDR_I == OFF_CARF_HI)
                carf_ff[39:32] <= PWDATA_I[7:0];
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_ff     <= MD_NONE;
            conflict_ff <= 1'b0;
        end else if (CE_I) begin
            if (am_req && car_bad) conflict_ff <= 1'b1;
            else if (wr && PADDR_I == OFF_STATUS && PWDATA_I[1])
                conflict_ff <= 1'b0;
            if (am_req) begin
                if (!car_bad) mode_ff <= MD_AM;
            end else if (wr && PADDR_I == OFF_AMSTATE) begin
                if (mode_ff == MD_AM) mode_ff <= MD_NONE;
            end else if (wr && PADDR_I == OFF_MODE) begin
                case (PWDATA_I[5:0])
                    MD_NONE, MD_FM, MD_BURST, MD_FSK, MD_SWEEP:
                        mode_ff <= pam_mode_t'(PWDATA_I[5:0]);
                    MD_AM: if (!car_bad) mode_ff <= MD_AM;
                    default: mode_ff <= mode_ff;
                endcase
            end else if (mode_ff == MD_AM && car_bad)
                mode_ff <= MD_NONE;
        end
    end

    // ************************************
    // Registered outputs
    // ************************************
    logic        am_on;
    logic [39:0] car_lim;
    assign am_on = (mode_ff == MD_AM);
    assign car_lim = (car_ff == SH_TRI || car_ff == SH_RAMP)
                     ? CARF_TRMAX : CARF_MAX;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PHASE_OFFSET_O      <= 16'h0;
            BURST_PHASE_O       <= 16'h0;
            ZERO_FIRST_SAMPLE_O <= 1'b0;
            LOCK_ERR_O          <= 1'b0;
            AM_DEPTH_O          <= DEP_RST[7:0];
            AM_SHAPE_O          <= SH_SIN;
            AM_RATE_O           <= RATE_RST[24:0];
            INT_MOD_EN_O        <= 1'b0;
            EXT_MOD_EN_O        <= 1'b1;
            DEPTH_FROM_EXT_O    <= 1'b0;
            MOD_MODE_O          <= MD_NONE;
            CARRIER_FREQ_O      <= CARF_RST;
        end else if (CE_I) begin
            PHASE_OFFSET_O      <= phase_ff;
            BURST_PHASE_O       <= burst_ff;
            ZERO_FIRST_SAMPLE_O <= (car_ff == SH_USER);
            LOCK_ERR_O          <= err_ff;
            AM_DEPTH_O          <= depth_ff;
            AM_SHAPE_O          <= shape_ff;
            AM_RATE_O           <= rate_ff;
            INT_MOD_EN_O        <= am_on & ~ext_only_ff;
            EXT_MOD_EN_O        <= 1'b1;
            DEPTH_FROM_EXT_O    <= am_on & ext_only_ff;
            MOD_MODE_O          <= mode_ff;
            CARRIER_FREQ_O      <= pick(SEL_VAL, carf_ff, CARF_MIN,
                                        car_lim);
        end
    end

    // ************************************
    // Assertions
    // ************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    property p_phase_lim;
        $signed(PHASE_OFFSET_O) <= PH_MAX_Q12
        && $signed(PHASE_OFFSET_O) >= -PH_MAX_Q12;
    endproperty
    a_phase_lim: assert property (p_phase_lim)
        else $error("phase offset out of range");
    property p_deg;
        wr && PADDR_I == OFF_PHASE && PWDATA_I[18:16] == 3'h1
        && PWDATA_I[15:0] == 16'h005A |=> phase_ff == 16'h1923;
    endproperty
    a_deg: assert property (p_deg)
        else $error("ninety degrees not converted");
    property p_zero_ref;
        CE_I |=> ZERO_FIRST_SAMPLE_O == ($past(car_ff) == SH_USER);
    endproperty
    a_zero_ref: assert property (p_zero_ref)
        else $error("zero phase reference wrong");
    property p_burst_sep;
        wr && PADDR_I == OFF_PHASE |=> $stable(burst_ff);
    endproperty
    a_burst_sep: assert property (p_burst_sep)
        else $error("burst phase disturbed");
    property p_rebase;
        wr && PADDR_I == OFF_CTRL && PWDATA_I[0]
        |=> PHASE_REBASE_O && $stable(phase_ff) ##1 !PHASE_REBASE_O;
    endproperty
    a_rebase: assert property (p_rebase)
        else $error("rebase pulse wrong");
    property p_lock_err;
        CE_I && loss && lock_en_ff |=> err_ff ##1 LOCK_ERR_O || !CE_I;
    endproperty
    a_lock_err: assert property (p_lock_err)
        else $error("lock loss not latched");
    property p_en_read;
        setup && !PWRITE_I && PADDR_I == OFF_LOCKEN
        |=> PRDATA_O == {31'h0, $past(lock_en_ff)};
    endproperty
    a_en_read: assert property (p_en_read)
        else $error("lock error enable readback wrong");
    property p_depth;
        wr && PADDR_I == OFF_DEPTH && PWDATA_I[9:8] == SEL_MAX
        |=> depth_ff == 8'h78;
    endproperty
    a_depth: assert property (p_depth)
        else $error("depth max not 120");
    property p_no_noise;
        am_req && car_bad |=> !am_on && conflict_ff;
    endproperty
    a_no_noise: assert property (p_no_noise)
        else $error("AM on noise or dc carrier");
    property p_rate;
        {15'h0, rate_ff} >= RATE_MIN && {15'h0, rate_ff} <= RATE_MAX;
    endproperty
    a_rate: assert property (p_rate)
        else $error("modulator rate out of range");
    property p_src;
        CE_I ##1 CE_I |-> INT_MOD_EN_O == ($past(am_on)
        && !$past(ext_only_ff)) && EXT_MOD_EN_O;
    endproperty
    a_src: assert property (p_src)
        else $error("source enables wrong");
    property p_onehot;
        am_req && !car_bad |=> $onehot(mode_ff) && am_on;
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("AM did not displace mode");
    property p_car;
        CARRIER_FREQ_O <= CARF_MAX && CARRIER_FREQ_O >= CARF_MIN;
    endproperty
    a_car: assert property (p_car)
        else $error("carrier frequency out of range");
    c_am_on:   cover property (am_req ##1 am_on);
    c_unlock:  cover property (lock_en_ff && loss ##1 err_ff);
    c_ext:     cover property (am_on && ext_only_ff);
    c_refused: cover property (am_req && car_bad);
endmodule // pam_ctrl

/* verif/pam_host_model.sv */
/*
 * APB host model that issues settings requests to the block.
 * Assumes a slave clocked by clk that answers within 32 cycles.
 */
module pam_host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    int hung = 0;
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ************************************
    // One transfer, held until pready
    // ************************************
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 32);
        if (n >= 32) hung++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
endmodule // pam_host_model

/* verif/tb_top.sv */
/*
 * Self-checking bench of the phase and AM settings block.
 * Assumes the APB host model and a 40 MHz clock.
 */
module tb_top
    import pam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        lock = 1'h1;
    logic        ce = 1'h1;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic        reb_o, zfs_o, lerr_o, int_o, ext_o, dfe_o;
    logic [7:0]  paddr, dep_o;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] ph_o, bph_o;
    logic [2:0]  shp_o;
    logic [24:0] rate_o;
    logic [5:0]  mode_o;
    logic [39:0] carf_o;
    int          fails = 0;
    int          checks_done = 0;
    int          rebases = 0;
    // ************************************
    // Clock and instances
    // ************************************
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (reb_o === 1'h1) rebases++;
    end
    pam_host_model host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    pam_ctrl dut_u (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .LOCK_I(lock),
        .PHASE_OFFSET_O(ph_o), .PHASE_REBASE_O(reb_o), .BURST_PHASE_O(bph_o),
        .ZERO_FIRST_SAMPLE_O(zfs_o), .LOCK_ERR_O(lerr_o), .AM_DEPTH_O(dep_o),
        .AM_SHAPE_O(shp_o), .AM_RATE_O(rate_o), .INT_MOD_EN_O(int_o),
        .EXT_MOD_EN_O(ext_o), .DEPTH_FROM_EXT_O(dfe_o), .MOD_MODE_O(mode_o),
        .CARRIER_FREQ_O(carf_o));
    // ************************************
    // Shared tasks
    // ************************************
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'h1, a, d, rd, err);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic rr(input logic [7:0] a);
        host_u.xfer(1'h0, a, 32'h0, rd, err);
    endtask
    task automatic give_verdict;
        fails += host_u.hung;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ************************************
    // Scenarios
    // ************************************
    task automatic t_reset;
        repeat (2) @(posedge clk);
        #1;
        chk(dep_o, 40'h64, "depth");
        chk(rate_o, 40'h186A0, "rate");
        chk(shp_o, 40'(SH_SIN), "shape");
        chk(mode_o, 40'(MD_NONE), "mode");
        chk(carf_o, 40'h989680, "carrier");
        chk(ext_o, 40'h1, "ext on");
        rr(OFF_AMSTATE);
        chk(rd, 40'h0, "am off");
        rr(OFF_LOCKEN);
        chk(rd, 40'h0, "lock err off");
        rr(OFF_SOURCE);
        chk(rd, 40'h0, "both");
        rr(8'h3C);
        chk(err, 40'h1, "unmapped");
        $display("test reset done at %0t", $time);
    endtask
    task automatic t_phase;
        logic [31:0] pin[6] = '{32'h0001FFA6, 32'h0001005A, 32'h00010168, 32'h00040000,
                                32'h00020000, 32'h00007530};
        logic [15:0] pex[6] = '{16'hE6DD, 16'h1923, 16'h6488, 16'h6488, 16'h9B78, 16'h6488};
        int          n;
        foreach (pin[i]) begin
            wr(OFF_PHASE, pin[i]);
            chk(ph_o, 40'(pex[i]), "phase");
            rr(OFF_PHASE);
            chk(rd, 40'({{16{pex[i][15]}}, pex[i]}), "rad");
        end
        n = rebases;
        wr(OFF_CTRL, 32'h1);
        chk(40'(rebases - n), 40'h1, "rebase pulse");
        chk(ph_o, 40'h6488, "offset kept");
        wr(OFF_BURSTPH, 32'h1234);
        chk(bph_o, 40'h1234, "burst phase");
        chk(ph_o, 40'h6488, "phase apart");
        $display("test phase done at %0t", $time);
    endtask
    task automatic t_lock;
        wr(OFF_LOCKEN, 32'h0);
        @(posedge clk);
        lock <= 1'h0;
        repeat (12) @(posedge clk);
        chk(lerr_o, 40'h0, "masked loss");
        lock <= 1'h1;
        wr(OFF_LOCKEN, 32'h1);
        rr(OFF_LOCKEN);
        chk(rd, 40'h1, "enable reads 1");
        @(posedge clk);
        lock <= 1'h0;
        for (int n = 0; n < 20 && lerr_o !== 1'h1; n++) @(posedge clk);
        chk(lerr_o, 40'h1, "loss flagged");
        rr(OFF_ERR);
        chk({rd[16], rd[9:0]}, 40'h644, "code");
        wr(OFF_ERR, 32'h10000);
        chk(lerr_o, 40'h0, "cleared");
        @(posedge clk);
        lock <= 1'h1;
        repeat (6) @(posedge clk);
        // Enable low: the loss must wait until it returns
        ce <= 1'h0;
        lock <= 1'h0;
        repeat (12) @(posedge clk);
        chk(lerr_o, 40'h0, "frozen by enable");
        ce <= 1'h1;
        for (int n = 0; n < 20 && lerr_o !== 1'h1; n++) @(posedge clk);
        chk(lerr_o, 40'h1, "loss after enable");
        wr(OFF_ERR, 32'h10000);
        chk(lerr_o, 40'h0, "cleared again");
        @(posedge clk);
        lock <= 1'h1;
        $display("test lock done at %0t", $time);
    endtask
    task automatic t_am;
        logic [31:0] td[8] = '{32'h200, 32'h100, 32'h96, 32'h37,
                               32'h4000000, 32'h2000000, 32'h5, 32'h3E8};
        logic [24:0] te[8] = '{25'h78, 25'h0, 25'h78, 25'h37,
                               25'h1312D00, 25'hA, 25'hA, 25'h3E8};
        pam_mode_t   mds[4] = '{MD_FM, MD_BURST, MD_FSK, MD_SWEEP};
        for (int i = 0; i < 8; i++) begin
            wr((i < 4) ? OFF_DEPTH : OFF_RATE, td[i]);
            chk((i < 4) ? 40'(dep_o) : 40'(rate_o), 40'(te[i]), "limit");
        end
        for (int s = 0; s < 6; s++) begin
            wr(OFF_SHAPE, 32'(s));
            chk(shp_o, 40'(s), "mod shape");
        end
        wr(OFF_SOURCE, 32'h1);
        foreach (mds[i]) begin
            wr(OFF_MODE, 32'(mds[i]));
            chk(mode_o, 40'(mds[i]), "other mode");
            wr(OFF_AMSTATE, 32'h1);
            chk(mode_o, 40'(MD_AM), "am displaces");
        end
        chk(dfe_o, 40'h1, "ext depth");
        chk(int_o, 40'h0, "int off");
        chk(ext_o, 40'h1, "ext kept");
        rr(OFF_AMSTATE);
        chk(rd, 40'h1, "am reads 1");
        wr(OFF_SOURCE, 32'h0);
        chk({int_o, dfe_o}, 40'h2, "both summed");
        wr(OFF_SHAPE, 32'h4);
        chk(mode_o, 40'(MD_AM), "noise modulator");
        wr(OFF_CARSHP, 32'h4);
        rr(OFF_AMSTATE);
        chk(rd, 40'h0, "noise carrier drops am");
        wr(OFF_MODE, 32'(MD_NONE));
        wr(OFF_STATUS, 32'h2);
        $display("test am done at %0t", $time);
    endtask
    task automatic t_carrier;
        logic [31:0] bad[2] = '{32'h4, 32'h6};
        wr(OFF_CARSHP, 32'h5);
        chk(zfs_o, 40'h1, "arb zero");
        wr(OFF_CARSHP, 32'h0);
        chk(zfs_o, 40'h0, "crossing zero");
        wr(OFF_CARF_LO, 32'hFFFFFFFF);
        wr(OFF_CARF_HI, 32'hFF);
        chk(carf_o, 40'h22ECB25C00, "carrier max");
        wr(OFF_CARSHP, 32'h2);
        chk(carf_o, 40'h3B9ACA00, "tri max");
        wr(OFF_CARSHP, 32'h3);
        wr(OFF_CARF_LO, 32'h0);
        wr(OFF_CARF_HI, 32'h0);
        chk(carf_o, 40'h1, "carrier min");
        foreach (bad[i]) begin
            wr(OFF_CARSHP, bad[i]);
            wr(OFF_AMSTATE, 32'h1);
            chk(mode_o, 40'(MD_NONE), "am refused");
            rr(OFF_STATUS);
            chk(rd[1], 40'h1, "conflict flag");
            wr(OFF_STATUS, 32'h2);
        end
        $display("test carrier done at %0t", $time);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_phase();
        t_lock();
        t_am();
        t_carrier();
        give_verdict();
    end
endmodule // tb_top
